// ==== capture_pkg.sv ====
/*
  Constants and carrier types for the timer input capture unit: register
  offsets, field positions, reset values and the register-port request.
  Assumes an 8-bit register port and a 20 MHz system clock.
*/
// How it works
// - capture fires when the selected input changes with the chosen edge
// - each capture copies the whole 16-bit counter into capture register
// - capture flag rises in the same cycle the capture register loads
// - flag raises the interrupt request while the irq enable bit is one
// - servicing the capture interrupt clears the flag by itself
// - writing one to the flag bit clears it, zero leaves it
// - low byte read first loads temp with high byte, high read returns temp
// - capture register writable only in modes using it as counter top
// - low byte write moves temp and written byte into register at once
// - one 8-bit temp register serves every 16-bit register of the timer
// - only timer one may take the comparator output as trigger source
// - source change may make a false capture, software clears the flag
// - pin and comparator are sampled and edge detected the same way
// - enabled noise filter adds exactly four cycles to capture latency
// - filter and edge detector stay live in top modes too, just no capture
// - driving the pin from the port output triggers like outside signal
// - filter output changes only when four samples agree on the new level
// - noise filter enable bit lives in timer control register b
// - filter runs on the undivided system clock, ignores the prescaler
// - every new capture overwrites the register whether read or not
package capture_pkg;

  // -------------------------------------------------------------------
  // register offsets on the 8-bit port
  // -------------------------------------------------------------------
  localparam logic [2:0] ADDR_CAP_LOW = 3'h0;
  localparam logic [2:0] ADDR_CAP_HIGH = 3'h1;
  localparam logic [2:0] ADDR_CTRL_B = 3'h2;
  localparam logic [2:0] ADDR_FLAGS = 3'h3;
  localparam logic [2:0] ADDR_IRQ_MASK = 3'h4;
  localparam logic [2:0] ADDR_COMP_CTRL = 3'h5;
  localparam logic [2:0] ADDR_COUNT_LOW = 3'h6;
  localparam logic [2:0] ADDR_COUNT_HIGH = 3'h7;

  // -------------------------------------------------------------------
  // field positions
  // -------------------------------------------------------------------
  localparam int BIT_NOISE_FILTER = 7;
  localparam int BIT_EDGE_SELECT = 6;
  localparam int WAVE_LSB = 0;
  localparam int WAVE_MSB = 3;
  localparam int BIT_CAPTURE_FLAG = 5;
  localparam int BIT_IRQ_ENABLE = 5;
  localparam int BIT_COMP_SELECT = 2;

  // -------------------------------------------------------------------
  // reset values and sizes
  // -------------------------------------------------------------------
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [15:0] WORD_ZERO = 16'h0000;
  localparam logic [3:0] WAVE_RESET = 4'h0;
  localparam int FILTER_SAMPLES = 4;
  localparam int CLK_HZ = 20000000;

  // one register-port request, sampled at a rising edge
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bus_req_type;

endpackage : capture_pkg

// ==== event_source.sv ====
/*
  Far-side model: the event sources on the capture pin and on the
  comparator output. Assumes the bench calls set from a process that
  follows clk_i, and that both levels start low.
*/
`timescale 1ns/1ps
`default_nettype none

module event_source (
  input wire logic clk_i, // system clock
  output logic pin_o, // capture pin level
  output logic comp_o // comparator output level
);
  // both sources idle low so the first rise is a real edge
  initial begin
    pin_o = 1'b0;
    comp_o = 1'b0;
  end

  // move one source after dly idle cycles; dly > 0 models a slow source
  task automatic set(input logic src, input logic lvl, input int dly);
    repeat (dly) @(posedge clk_i);
    @(posedge clk_i);
    if (src)
      comp_o <= lvl; // comparator path
    else
      pin_o <= lvl; // port output looped back onto the pin
  endtask : set
endmodule : event_source

`default_nettype wire

// ==== testbench.sv ====
/*
  Self-checking bench for the timer input capture unit.
  Assumes event_source drives the trigger inputs and that the counter
  input may be any free-running value on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import capture_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  bus_req_type req = '0;
  logic irq_ack = 1'b0;
  logic [15:0] cnt = 16'h0000;
  logic [7:0] rdata, lo, hi;
  logic pin, comp, irq, load;
  logic [15:0] cap, load_val, e;
  logic [3:0] mode;
  int err_total = 0;
  int samples_checked = 0;

  // 50 ns period
  always #25 core_clk = ~core_clk;
  // both bytes move every cycle so a one-cycle slip shows in either byte
  always @(posedge core_clk) cnt <= cnt + 16'h0101;

  timer_input_capture_unit dut (.core_clk_i(core_clk), .rst_n_i(rst_n),
    .reg_req_i(req), .rdata_o(rdata), .capture_pin_i(pin),
    .comparator_output_i(comp), .counter_value_i(cnt),
    .irq_ack_i(irq_ack), .capture_irq_o(irq), .capture_register_o(cap),
    .waveform_mode_field_o(mode), .counter_load_o(load),
    .counter_load_value_o(load_val));
  event_source src (.clk_i(core_clk), .pin_o(pin), .comp_o(comp));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge core_clk);
    req <= '0;
  endtask : wr

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge core_clk);
    req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge core_clk);
    req <= '0;
    #1 d = rdata;
  endtask : rd

  // low then high read with no gap, as software reads a 16-bit value
  task automatic rd_pair(input logic [2:0] a_lo, input logic [2:0] a_hi,
                         output logic [7:0] d_lo, output logic [7:0] d_hi);
    @(posedge core_clk);
    req <= '{a_lo, 8'h00, 1'b0, 1'b1};
    @(posedge core_clk);
    req <= '{a_hi, 8'h00, 1'b0, 1'b1};
    #1 d_lo = rdata;
    @(posedge core_clk);
    req <= '0;
    #1 d_hi = rdata;
  endtask : rd_pair

  // move a source, then check that no interrupt request shows one cycle early and the
  // counter value sampled k cycles later shows exactly on time
  task automatic trig(input logic s, input logic l, input int k);
    src.set(s, l, 0);
    #1 e = cnt + 16'(k) * 16'h0101;
    repeat (k) @(posedge core_clk);
    #1 chk(irq, 16'h0000);
    @(posedge core_clk);
    #1 chk(cap, e);
    chk(irq, 16'h0001);
  endtask : trig

  // wait, then expect no capture interrupt request raised
  task automatic quiet(input int n);
    repeat (n) @(posedge core_clk);
    #1 chk(irq, 16'h0000);
  endtask : quiet

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic s_edges();
    wr(ADDR_IRQ_MASK, 8'h20);
    wr(ADDR_CTRL_B, 8'h40);
    trig(1'b0, 1'b1, 2);
    wr(ADDR_FLAGS, 8'h20);
    src.set(1'b0, 1'b0, 0);
    quiet(6);
    wr(ADDR_CTRL_B, 8'h00);
    wr(ADDR_FLAGS, 8'h20);
    src.set(1'b0, 1'b1, 0);
    quiet(6);
    trig(1'b0, 1'b0, 2);
  endtask : s_edges

  // a three-cycle glitch must not pass the filter; a clean edge is late
  task automatic s_filter();
    wr(ADDR_CTRL_B, 8'hC0);
    wr(ADDR_FLAGS, 8'h20);
    src.set(1'b0, 1'b1, 0);
    src.set(1'b0, 1'b0, 2);
    quiet(10);
    trig(1'b0, 1'b1, 6);
  endtask : s_filter

  task automatic s_flag();
    wr(ADDR_CTRL_B, 8'h40);
    src.set(1'b0, 1'b0, 0);
    repeat (4) @(posedge core_clk);
    wr(ADDR_FLAGS, 8'h20);
    trig(1'b0, 1'b1, 2);
    src.set(1'b0, 1'b0, 0);
    src.set(1'b0, 1'b1, 0);
    #1 e = cnt + 16'h0202;
    repeat (4) @(posedge core_clk);
    #1 chk(cap, e);
    rd(ADDR_FLAGS, lo);
    chk(lo, 8'h20);
    wr(ADDR_FLAGS, 8'h00);
    #1 chk(irq, 16'h0001);
    wr(ADDR_IRQ_MASK, 8'h00);
    #1 chk(irq, 16'h0000);
    wr(ADDR_IRQ_MASK, 8'h20);
    #1 chk(irq, 16'h0001);
    @(posedge core_clk);
    irq_ack <= 1'b1;
    @(posedge core_clk);
    irq_ack <= 1'b0;
    #1 chk(irq, 16'h0000);
    src.set(1'b0, 1'b0, 0);
    trig(1'b0, 1'b1, 2);
    wr(ADDR_FLAGS, 8'h20);
    #1 chk(irq, 16'h0000);
    rd_pair(ADDR_CAP_LOW, ADDR_CAP_HIGH, lo, hi);
    chk({hi, lo}, e);
  endtask : s_flag

  // comparator as source: the pin is ignored, the comparator captures
  task automatic s_comp();
    wr(ADDR_COMP_CTRL, 8'h04);
    repeat (4) @(posedge core_clk);
    wr(ADDR_FLAGS, 8'h20);
    src.set(1'b0, 1'b0, 0);
    src.set(1'b0, 1'b1, 0);
    quiet(6);
    trig(1'b1, 1'b1, 2);
    wr(ADDR_COMP_CTRL, 8'h00);
    repeat (4) @(posedge core_clk);
    wr(ADDR_FLAGS, 8'h20);
  endtask : s_comp

  // writes refused outside top modes; temp shared by every 16-bit pair
  task automatic s_top();
    wr(ADDR_CAP_HIGH, 8'h12);
    wr(ADDR_CAP_LOW, 8'h34);
    #1 chk(cap, e);
    wr(ADDR_CTRL_B, 8'h48);
    repeat (4) @(posedge core_clk);
    wr(ADDR_FLAGS, 8'h20);
    wr(ADDR_CAP_HIGH, 8'hAB); // pins quiet while top changes
    wr(ADDR_CAP_LOW, 8'hCD);
    #1 chk(cap, 16'hABCD);
    chk(mode, 4'h8);
    wr(ADDR_COUNT_HIGH, 8'h5A);
    wr(ADDR_CAP_LOW, 8'h01);
    #1 chk(cap, 16'h5A01);
    wr(ADDR_COUNT_HIGH, 8'h77);
    wr(ADDR_COUNT_LOW, 8'h88);
    #1 chk(load, 16'h0001);
    chk(load_val, 16'h7788);
    @(posedge core_clk);
    #1 chk(load, 16'h0000);
    src.set(1'b0, 1'b0, 0);
    src.set(1'b0, 1'b1, 0);
    quiet(8);
    chk(cap, 16'h5A01);
  endtask : s_top

  // main sequence: reset held six cycles, then every scenario in turn
  initial begin
    repeat (5) @(posedge core_clk);
    #1 chk(cap, 16'h0000);
    chk(irq, 16'h0000);
    @(posedge core_clk);
    rst_n <= 1'b1;
    rd(ADDR_CTRL_B, lo);
    chk(lo, 8'h00);
    @(posedge core_clk);
    #1 chk(rdata, 8'h00); // read data stands one cycle only
    s_edges();
    s_filter();
    s_flag();
    s_comp();
    s_top();
    end_of_test();
  end

  // watchdog: the scenarios need well under a thousand cycles
  initial begin
    repeat (20000) @(posedge core_clk);
    err_total++;
    end_of_test();
  end
endmodule : testbench

`default_nettype wire

// ==== timer_input_capture_unit.sv ====
/*
  Input capture unit of a 16-bit timer: trigger select, synchroniser,
  optional four-sample noise filter, edge detector, capture register with
  the shared high-byte temp, flag and interrupt request.
  Assumes the counter value comes from the counter unit on the same clock,
  and that the pin and comparator inputs are asynchronous.
*/
`timescale 1ns/1ps
`default_nettype none

module timer_input_capture_unit
  import capture_pkg::*;
#(
  parameter int HAS_COMPARATOR = 1, // 1 on timer one only
  parameter logic [15:0] TOP_MODES = 16'h5500 // modes using capture as top
) (
  input wire logic core_clk_i, // system clock, 20 MHz
  input wire logic rst_n_i, // synchronous reset, active low
  input wire bus_req_type reg_req_i, // register port request
  output logic [7:0] rdata_o, // read data, cycle after read strobe
  input wire logic capture_pin_i, // capture pin level, asynchronous
  input wire logic comparator_output_i, // comparator output, asynchronous
  input wire logic [15:0] counter_value_i, // running counter value
  input wire logic irq_ack_i, // capture interrupt being serviced
  output logic capture_irq_o, // capture interrupt request
  output logic [15:0] capture_register_o, // captured value or top
  output logic [3:0] waveform_mode_field_o, // waveform mode to counter
  output logic counter_load_o, // one-cycle counter write pulse
  output logic [15:0] counter_load_value_o // value for counter write
);

  // -------------------------------------------------------------------
  // elaboration checks
  // -------------------------------------------------------------------
  if (HAS_COMPARATOR != 0 && HAS_COMPARATOR != 1) begin : g_bad_param
    $error("HAS_COMPARATOR must be 0 or 1");
  end

  // -------------------------------------------------------------------
  // state
  // -------------------------------------------------------------------
  logic [15:0] capture_register;
  logic [7:0] temp_high;
  logic noise_filter_enable;
  logic trigger_edge_select;
  logic [3:0] waveform_mode_field;
  logic capture_flag;
  logic capture_irq_enable;
  logic comparator_trigger_select;
  logic [1:0] pin_sync;
  logic [1:0] comp_sync;
  logic [FILTER_SAMPLES-2:0] filter_hist;
  logic filter_out;
  logic edge_last;
  logic edge_src;
  logic sel_raw;
  logic top_mode;
  logic capture_now;
  logic wr_low_top;

  // -------------------------------------------------------------------
  // synchronisers and trigger source
  // -------------------------------------------------------------------
  // both inputs use the same two-flop path, so latency does not depend on
  // source; port drive on the pin loops back through the pad the same way
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      pin_sync <= 2'h0;
      comp_sync <= 2'h0;
    end else begin
      pin_sync <= {pin_sync[0], capture_pin_i};
      comp_sync <= {comp_sync[0], comparator_output_i};
    end
  end

  // comparator source exists only when the parameter allows it
  assign sel_raw = (HAS_COMPARATOR == 1 && comparator_trigger_select) ?
                   comp_sync[1] : pin_sync[1];

  // -------------------------------------------------------------------
  // noise filter
  // -------------------------------------------------------------------
  // current sample plus three held ones make four; running every system
  // clock keeps the added delay at exactly four cycles
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      filter_hist <= '0;
      filter_out <= 1'b0;
    end else begin
      filter_hist <= {filter_hist[FILTER_SAMPLES-3:0], sel_raw};
      if (filter_hist == {(FILTER_SAMPLES-1){sel_raw}}) begin
        filter_out <= sel_raw;
      end
    end
  end

  // -------------------------------------------------------------------
  // edge detector
  // -------------------------------------------------------------------
  // switching filter or source can look like an edge; software must clear
  // the flag afterwards
  assign edge_src = noise_filter_enable ? filter_out : sel_raw;

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      edge_last <= 1'b0;
    end else begin
      edge_last <= edge_src;
    end
  end

  assign top_mode = TOP_MODES[waveform_mode_field];
  // rising when select is one, falling when zero; inhibited in top modes
  assign capture_now = !top_mode && (edge_src != edge_last) &&
                       (edge_src == trigger_edge_select);
  assign wr_low_top = reg_req_i.wr && reg_req_i.addr == ADDR_CAP_LOW &&
                      top_mode;

  // -------------------------------------------------------------------
  // capture register
  // -------------------------------------------------------------------
  // no capture is possible in top modes, so the write never collides
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      capture_register <= WORD_ZERO;
    end else if (capture_now) begin
      capture_register <= counter_value_i;
    end else if (wr_low_top) begin
      capture_register <= {temp_high, reg_req_i.wdata};
    end
  end

  // -------------------------------------------------------------------
  // shared high-byte temp
  // -------------------------------------------------------------------
  // one temp for every 16-bit register: any high write or low read hits it
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      temp_high <= BYTE_ZERO;
    end else if (reg_req_i.wr && (reg_req_i.addr == ADDR_CAP_HIGH ||
                 reg_req_i.addr == ADDR_COUNT_HIGH)) begin
      temp_high <= reg_req_i.wdata;
    end else if (reg_req_i.rd && reg_req_i.addr == ADDR_CAP_LOW) begin
      temp_high <= capture_register[15:8];
    end else if (reg_req_i.rd && reg_req_i.addr == ADDR_COUNT_LOW) begin
      temp_high <= counter_value_i[15:8];
    end
  end

  // -------------------------------------------------------------------
  // capture flag
  // -------------------------------------------------------------------
  // set wins over both clears so an event in the clear cycle is kept
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      capture_flag <= 1'b0;
    end else if (capture_now) begin
      capture_flag <= 1'b1;
    end else if (irq_ack_i) begin
      capture_flag <= 1'b0;
    end else if (reg_req_i.wr && reg_req_i.addr == ADDR_FLAGS &&
                 reg_req_i.wdata[BIT_CAPTURE_FLAG]) begin
      capture_flag <= 1'b0;
    end
  end

  // -------------------------------------------------------------------
  // control registers
  // -------------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      noise_filter_enable <= 1'b0;
      trigger_edge_select <= 1'b0;
      waveform_mode_field <= WAVE_RESET;
    end else if (reg_req_i.wr && reg_req_i.addr == ADDR_CTRL_B) begin
      noise_filter_enable <= reg_req_i.wdata[BIT_NOISE_FILTER];
      trigger_edge_select <= reg_req_i.wdata[BIT_EDGE_SELECT];
      waveform_mode_field <= reg_req_i.wdata[WAVE_MSB:WAVE_LSB];
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      capture_irq_enable <= 1'b0;
    end else if (reg_req_i.wr && reg_req_i.addr == ADDR_IRQ_MASK) begin
      capture_irq_enable <= reg_req_i.wdata[BIT_IRQ_ENABLE];
    end
  end

  // the select bit stays zero on a timer without the comparator path
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      comparator_trigger_select <= 1'b0;
    end else if (reg_req_i.wr && reg_req_i.addr == ADDR_COMP_CTRL) begin
      comparator_trigger_select <= (HAS_COMPARATOR == 1) &&
                                   reg_req_i.wdata[BIT_COMP_SELECT];
    end
  end

  // -------------------------------------------------------------------
  // counter write through the temp
  // -------------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      counter_load_o <= 1'b0;
      counter_load_value_o <= WORD_ZERO;
    end else begin
      counter_load_o <= reg_req_i.wr && reg_req_i.addr == ADDR_COUNT_LOW;
      if (reg_req_i.wr && reg_req_i.addr == ADDR_COUNT_LOW) begin
        counter_load_value_o <= {temp_high, reg_req_i.wdata};
      end
    end
  end

  // -------------------------------------------------------------------
  // read data
  // -------------------------------------------------------------------
  // registered so data stands only in the cycle after the strobe
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      rdata_o <= BYTE_ZERO;
    end else if (!reg_req_i.rd) begin
      rdata_o <= BYTE_ZERO;
    end else begin
      unique case (reg_req_i.addr)
        ADDR_CAP_LOW: rdata_o <= capture_register[7:0];
        ADDR_CAP_HIGH: rdata_o <= temp_high;
        ADDR_CTRL_B: rdata_o <= {noise_filter_enable, trigger_edge_select,
                                 2'h0, waveform_mode_field};
        ADDR_FLAGS: rdata_o <= {2'h0, capture_flag, 5'h00};
        ADDR_IRQ_MASK: rdata_o <= {2'h0, capture_irq_enable, 5'h00};
        ADDR_COMP_CTRL: rdata_o <= {5'h00, comparator_trigger_select, 2'h0};
        ADDR_COUNT_LOW: rdata_o <= counter_value_i[7:0];
        ADDR_COUNT_HIGH: rdata_o <= temp_high;
      endcase
    end
  end

  // -------------------------------------------------------------------
  // outputs
  // -------------------------------------------------------------------
  assign capture_irq_o = capture_flag && capture_irq_enable;
  assign capture_register_o = capture_register;
  assign waveform_mode_field_o = waveform_mode_field;

  // -------------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  // a synchronised level seen at cycle t is the raw pin two edges earlier;
  // the guard skips the two cycles that still hold reset values
  a_sync_latency: assert property (
    $past(rst_n_i, 2) |-> pin_sync[1] == $past(capture_pin_i, 2))
    else $error("pin synchroniser latency is not two cycles");

  a_flag_with_capture: assert property (
    capture_now |=> capture_flag &&
                    capture_register == $past(counter_value_i))
    else $error("flag or value missing after capture");

  a_capture_value_only: assert property (
    $changed(capture_register) |-> $past(capture_now) || $past(wr_low_top))
    else $error("capture register changed without cause");

  a_irq_gate: assert property (
    capture_now && capture_irq_enable && !reg_req_i.wr |=> capture_irq_o)
    else $error("enabled capture raised no interrupt request");

  a_ack_clears: assert property (
    irq_ack_i && !capture_now |=> !capture_flag)
    else $error("service did not clear flag");

  a_flag_cause: assert property (
    $rose(capture_flag) |-> $past(capture_now))
    else $error("flag set without capture");

  a_w1c_flag: assert property (
    reg_req_i.wr && reg_req_i.addr == ADDR_FLAGS &&
    reg_req_i.wdata[BIT_CAPTURE_FLAG] && !capture_now |=> !capture_flag)
    else $error("writing one did not clear the flag");

  a_low_read_temp: assert property (
    reg_req_i.rd && reg_req_i.addr == ADDR_CAP_LOW ##1
    reg_req_i.rd && reg_req_i.addr == ADDR_CAP_HIGH
    |=> rdata_o == $past(capture_register[15:8], 2))
    else $error("high read did not return latched byte");

  a_no_capture_top: assert property (
    top_mode && !wr_low_top |=>
    $stable(capture_register) && !$rose(capture_flag))
    else $error("capture taken in a top mode");

  a_top_write_only: assert property (
    reg_req_i.wr && reg_req_i.addr == ADDR_CAP_LOW && !top_mode &&
    !capture_now |=> $stable(capture_register))
    else $error("capture register written outside top mode");

  a_filter_agree: assert property (
    $changed(filter_out) |-> $past(sel_raw) == filter_out &&
    $past(filter_hist) == {(FILTER_SAMPLES-1){filter_out}})
    else $error("filter changed before four samples agreed");

  a_filter_delay: assert property (
    noise_filter_enable && $changed(sel_raw) ##1
    $stable(sel_raw) [*3] |=> filter_out == $past(sel_raw))
    else $error("filter delay is not four cycles");

  a_rising_edge: assert property (
    trigger_edge_select && !top_mode && $rose(edge_src) |-> capture_now)
    else $error("rising edge missed with rising select");

  a_falling_edge: assert property (
    !trigger_edge_select && !top_mode && $fell(edge_src) |-> capture_now)
    else $error("falling edge missed with falling select");

  a_comp_lock: assert property (
    HAS_COMPARATOR == 0 |-> !comparator_trigger_select)
    else $error("comparator source on a timer without it");

endmodule : timer_input_capture_unit

`default_nettype wire
